// ### dv/fieldbus_flags_sva.sv
// Concurrent checks on the fieldbus host flag bank ports
`timescale 1ns/1ps
module fieldbus_flags_sva
  import fieldbus_flags_pkg::*;
(
  input wire logic                       CLOCK_IN,
  input wire logic                       RESET_N_IN,
  input wire logic [POINT_COUNT-1:0]     COMMAND_POINTS_IN,
  input wire logic [POINT_COUNT-1:0]     STATUS_POINTS_OUT,
  input wire logic                       GROUND_SHORT_IN,
  input wire logic                       LINE_OPEN_IN,
  input wire logic                       WATCHDOG_ERROR_IN,
  input wire logic [SETTING_WIDTH-1:0]   POINT_SETTING_IN,
  input wire logic                       WAVE_MODE_IN,
  input wire logic [ERR_COUNT_WIDTH-1:0] ERROR_COUNT_OUT,
  input wire logic                       ALARM_OUT,
  input wire logic                       WAVEFORM_ENABLE_OUT,
  input wire logic                       DETECT_START_OUT
);
  default clocking @(posedge CLOCK_IN); endclocking
  default disable iff (!RESET_N_IN);
  sequence disc_drop;
    $fell(STATUS_POINTS_OUT[4]);
  endsequence
  sequence clear_sent;
    $past(COMMAND_POINTS_IN[0], 4) || $past(COMMAND_POINTS_IN[0], 5);
  endsequence
  a_wd_drops_ok: assert property (
    WATCHDOG_ERROR_IN |-> ##5 !STATUS_POINTS_OUT[0])
    else $error("ok flag still high after watchdog error");
  a_ok_only_wd: assert property (
    $fell(STATUS_POINTS_OUT[0]) |->
      $past(WATCHDOG_ERROR_IN, 3))
    else $error("ok flag dropped without watchdog error");
  a_short_follows: assert property (
    GROUND_SHORT_IN [*8] |-> STATUS_POINTS_OUT[1])
    else $error("ground short flag missing");
  a_short_clears: assert property (
    (!GROUND_SHORT_IN) [*8] |-> !STATUS_POINTS_OUT[1])
    else $error("ground short flag stuck");
  a_disc_sets: assert property (
    LINE_OPEN_IN [*8] |-> STATUS_POINTS_OUT[4])
    else $error("disconnect flag missing");
  a_drop_needs_clear: assert property (
    disc_drop |-> clear_sent)
    else $error("disconnect flag dropped without clear");
  a_drop_zero_count: assert property (
    disc_drop |-> ERROR_COUNT_OUT == ERR_COUNT_ZERO)
    else $error("error count kept after clear");
  a_mirror_tracks: assert property (
    $stable(POINT_SETTING_IN) [*8] |->
      STATUS_POINTS_OUT[11:8] == POINT_SETTING_IN)
    else $error("point count mirror wrong");
  a_reserved_quiet: assert property (
    (STATUS_POINTS_OUT & 32'hFFEF_F0E0) == POINTS_ZERO)
    else $error("reserved status point set");
  a_start_busy: assert property (
    DETECT_START_OUT |=> STATUS_POINTS_OUT[20] && !DETECT_START_OUT)
    else $error("detect start pulse or busy flag wrong");
  a_count_bound: assert property (
    ERROR_COUNT_OUT <= ERR_COUNT_MAX)
    else $error("error count above limit");
  a_alarm_steady: assert property (
    STATUS_POINTS_OUT[4] |-> ALARM_OUT)
    else $error("alarm off during disconnect");
  a_wave_auto: assert property (
    (!WAVE_MODE_IN && STATUS_POINTS_OUT[0]) [*8] |-> WAVEFORM_ENABLE_OUT)
    else $error("waveform off in automatic mode");
  a_wave_cmd: assert property (
    $rose(WAVEFORM_ENABLE_OUT) |-> !WAVE_MODE_IN ||
      $past(COMMAND_POINTS_IN[2], 3) || $past(COMMAND_POINTS_IN[2], 4))
    else $error("waveform started without command");
endmodule : fieldbus_flags_sva

bind fieldbus_master_host_flags fieldbus_flags_sva u_sva (
  .CLOCK_IN(CLOCK_IN), .RESET_N_IN(RESET_N_IN),
  .COMMAND_POINTS_IN(COMMAND_POINTS_IN),
  .STATUS_POINTS_OUT(STATUS_POINTS_OUT),
  .GROUND_SHORT_IN(GROUND_SHORT_IN), .LINE_OPEN_IN(LINE_OPEN_IN),
  .WATCHDOG_ERROR_IN(WATCHDOG_ERROR_IN),
  .POINT_SETTING_IN(POINT_SETTING_IN), .WAVE_MODE_IN(WAVE_MODE_IN),
  .ERROR_COUNT_OUT(ERROR_COUNT_OUT), .ALARM_OUT(ALARM_OUT),
  .WAVEFORM_ENABLE_OUT(WAVEFORM_ENABLE_OUT),
  .DETECT_START_OUT(DETECT_START_OUT));

// ### dv/host_cmd_model.sv
// Host model that raises one request's command points at a time
`timescale 1ns/1ps
module host_cmd_model
  import fieldbus_flags_pkg::*;
(
  input  wire logic         clk_in,
  input  wire logic         rst_n_in,
  input  wire logic [2:0]   req_in,
  output command_points_type cmd_out,
  output logic              busy_out
);
  logic [3:0] cnt_reg;
  logic [2:0] hold_reg;
  assign busy_out = cnt_reg != 4'h0;
  assign cmd_out  = {29'h0, hold_reg};
  // Six cycles high, then five low before the next command
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_reg  <= 4'h0;
      hold_reg <= 3'h0;
    end else if (cnt_reg != 4'h0) begin
      cnt_reg <= cnt_reg - 4'h1;
      if (cnt_reg == 4'h5) hold_reg <= 3'h0;
    end else if (req_in != 3'h0) begin
      cnt_reg  <= 4'hA;
      hold_reg <= req_in;
    end
  end
endmodule : host_cmd_model

// ### dv/testbench.sv
// Self-checking bench for the fieldbus host flag bank
`timescale 1ns/1ps
module testbench;
  import fieldbus_flags_pkg::*;
  logic [2:0]         shorts = 3'h0;
  logic [2:0]         causes = 3'h0;
  logic [2:0]         req    = 3'h0;
  logic               clk    = 1'b0;
  logic               rst_n  = 1'b0;
  logic               wd     = 1'b0;
  logic               mode   = 1'b0;
  logic               done   = 1'b0;
  logic               ev     = 1'b0;
  logic [3:0]         setting = 4'h0;
  logic [3:0]         s;
  logic [9:0]         addr   = 10'h000;
  logic [9:0]         a;
  logic [9:0]         keep [130];
  logic [6:0]         ridx   = 7'h00;
  logic [6:0]         k;
  int                 n_high;
  command_points_type cmd;
  status_points_type  st;
  logic [9:0]         rdata;
  logic [7:0]         cnt;
  logic               alarm;
  logic               wave;
  logic               start;
  int                 n_fail;
  int                 checks_done;
  int                 cycles;
  int                 n_start;

  fieldbus_master_host_flags #(.FAST_HALF_CYCLES(4), .SLOW_HALF_CYCLES(8))
  u_fieldbus_master_host_flags (
    .CLOCK_IN(clk), .RESET_N_IN(rst_n), .COMMAND_POINTS_IN(cmd),
    .STATUS_POINTS_OUT(st), .GROUND_SHORT_IN(shorts[0]),
    .SUPPLY_SHORT_IN(shorts[1]), .SUPPLY_LOW_IN(shorts[2]),
    .LINE_OPEN_IN(causes[0]), .SLAVE_ERROR_IN(causes[1]),
    .SLAVE_POWER_OFF_IN(causes[2]), .WATCHDOG_ERROR_IN(wd),
    .POINT_SETTING_IN(setting), .WAVE_MODE_IN(mode),
    .DETECT_SWITCH_IN(1'b0), .DETECT_DONE_IN(done),
    .ERROR_ADDR_VALID_IN(ev), .ERROR_ADDR_IN(addr),
    .ERROR_READ_INDEX_IN(ridx), .ERROR_READ_DATA_OUT(rdata),
    .ERROR_COUNT_OUT(cnt), .ALARM_OUT(alarm),
    .WAVEFORM_ENABLE_OUT(wave), .DETECT_START_OUT(start));

  host_cmd_model u_host_cmd_model (.clk_in(clk), .rst_n_in(rst_n),
    .req_in(req), .cmd_out(cmd), .busy_out());

  always #2.5 clk = ~clk;

  always @(posedge clk) begin
    cycles++;
    if (start === 1'b1) n_start++;
    if (cycles == 5000) begin
      n_fail++;
      give_verdict();
    end
  end

  task w(input int n);
    repeat (n) @(posedge clk);
  endtask : w
  task look(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : look
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task command(input logic [2:0] r);
    w(1);
    req <= r;
    w(1);
    req <= 3'h0;
    look(12);
  endtask : command
  task do_reset(input logic m);
    w(1);
    rst_n <= 1'b0;
    mode  <= m;
    w(12);
    rst_n <= 1'b1;
    look(14);
  endtask : do_reset
  task give_verdict;
    $display("Checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : give_verdict

  function automatic logic [31:0] flags(input logic [3:0] v);
    return {27'h0, v, 1'b1};
  endfunction : flags
  function automatic logic [31:0] count_after(input int adds);
    return (adds > int'(ERR_LIST_DEPTH)) ? ERR_LIST_DEPTH : adds;
  endfunction : count_after

  initial begin
    void'($urandom(32'h50dea8d8));
    do_reset(1'b0);
    chk("wave", 32'h1, wave);
    for (int i = 0; i < 5; i++) begin
      s = (i == 0) ? 4'h8 : 4'($urandom);
      w(1);
      setting <= s;
      look(6);
      chk("mirror", {20'h0, s, 8'h0}, st & 32'hFFEF_FFE0);
    end
    $display("Test mirror done");
    for (int i = 0; i < 3; i++) begin
      w(1);
      shorts <= 3'(1 << i);
      look(6);
      chk("flags", flags(4'(1 << i)), st & 32'h1F);
      n_high = 0;
      repeat (16) begin
        look(1);
        n_high += int'(alarm === 1'b1);
      end
      chk("blink", 32'h8, n_high);
      w(1);
      shorts <= 3'h0;
      look(6);
      chk("flags", flags(4'h0), st & 32'h1F);
    end
    $display("Test shorts done");
    for (int i = 0; i < 3; i++) begin
      a = 10'($urandom);
      w(1);
      causes <= 3'(1 << i);
      ev     <= 1'b1;
      addr   <= a;
      w(1);
      ev <= 1'b0;
      look(6);
      chk("flags", flags(4'h8), st & 32'h1F);
      chk("alarm", 32'h1, alarm);
      chk("data", a, rdata);
      command(3'h1);
      chk("flags", flags(4'h8), st & 32'h1F);
      chk("count", 32'h1, cnt);
      w(1);
      causes <= 3'h0;
      look(6);
      chk("flags", flags(4'h8), st & 32'h1F);
      command(3'h1);
      chk("flags", flags(4'h0), st & 32'h1F);
      chk("count", 32'h0, cnt);
    end
    $display("Test disconnect done");
    w(1);
    ev <= 1'b1;
    for (int i = 0; i < 130; i++) begin
      keep[i] = 10'($urandom);
      addr <= keep[i];
      w(1);
    end
    ev <= 1'b0;
    look(2);
    chk("count", count_after(130), cnt);
    for (int i = 0; i < 4; i++) begin
      k = (i == 0) ? 7'h7F : 7'($urandom);
      w(1);
      ridx <= k;
      look(2);
      chk("data", keep[k], rdata);
    end
    command(3'h1);
    chk("count", 32'h0, cnt);
    chk("data", 32'h0, rdata);
    $display("Test error list done");
    n_start = 0;
    w(1);
    req <= 3'h2;
    w(1);
    req <= 3'h0;
    look(5);
    chk("busy", 32'h1, st.detect_busy_flag);
    look(10);
    chk("starts", 32'h1, n_start);
    w(1);
    done <= 1'b1;
    w(1);
    done <= 1'b0;
    look(3);
    chk("busy", 32'h0, st.detect_busy_flag);
    $display("Test detection done");
    w(1);
    wd <= 1'b1;
    look(6);
    chk("ok", 32'h0, st.operating_ok_flag);
    w(1);
    wd <= 1'b0;
    do_reset(1'b1);
    chk("wave", 32'h0, wave);
    command(3'h4);
    chk("wave", 32'h1, wave);
    $display("Test waveform done");
    give_verdict();
  end
endmodule : testbench

// ### hdl/fieldbus_flags_pkg.sv
// Constants and point layouts shared by the fieldbus host flag bank
package fieldbus_flags_pkg;

  localparam int unsigned POINT_COUNT      = 32;
  localparam int unsigned SETTING_WIDTH    = 4;
  localparam int unsigned ERR_ADDR_WIDTH   = 10;
  localparam int unsigned ERR_LIST_DEPTH   = 128;
  localparam int unsigned ERR_INDEX_WIDTH  = 7;
  localparam int unsigned ERR_COUNT_WIDTH  = 8;
  localparam int unsigned SYNC_WIDTH       = 45;

  localparam logic [ERR_COUNT_WIDTH-1:0] ERR_COUNT_MAX  = 8'h80;
  localparam logic [ERR_COUNT_WIDTH-1:0] ERR_COUNT_ZERO = 8'h00;
  localparam logic [ERR_ADDR_WIDTH-1:0]  ERR_ADDR_ZERO  = 10'h000;
  localparam logic [POINT_COUNT-1:0]     POINTS_ZERO    = 32'h0000_0000;
  localparam logic                       WAVE_MODE_CMD  = 1'h1;

  // Alarm blink timing
  localparam int unsigned CLOCK_KHZ        = 200000;
  localparam int unsigned FAST_BLINK_MS    = 125;
  localparam int unsigned SLOW_BLINK_MS    = 500;
  localparam int unsigned FAST_BLINK_CYCLES = FAST_BLINK_MS * CLOCK_KHZ;
  localparam int unsigned SLOW_BLINK_CYCLES = SLOW_BLINK_MS * CLOCK_KHZ;
  localparam int unsigned BLINK_CNT_WIDTH  = 32;

  // Status input points seen by the host, bit 0 at the bottom
  typedef struct packed {
    logic [10:0]              reserved_top;
    logic                     detect_busy_flag;
    logic [3:0]               reserved_upper;
    logic [3:0]               reserved_mid;
    logic [SETTING_WIDTH-1:0] point_count_mirror;
    logic [2:0]               reserved_low;
    logic                     line_disconnect_flag;
    logic                     supply_fault_flag;
    logic                     signal_supply_short_flag;
    logic                     signal_ground_short_flag;
    logic                     operating_ok_flag;
  } status_points_type;

  // Command output points driven by the host
  typedef struct packed {
    logic [28:0] reserved;
    logic        waveform_start_cmd;
    logic        address_detect_cmd;
    logic        disconnect_clear_cmd;
  } command_points_type;

  // Every pin-level input that passes the synchroniser
  typedef struct packed {
    command_points_type       cmd;
    logic                     ground_short;
    logic                     supply_short;
    logic                     supply_low;
    logic                     line_open;
    logic                     slave_error;
    logic                     slave_power_off;
    logic                     watchdog_error;
    logic [SETTING_WIDTH-1:0] point_setting;
    logic                     wave_mode;
    logic                     detect_switch;
  } sync_in_type;

endpackage : fieldbus_flags_pkg

// ### hdl/fieldbus_master_host_flags.sv
// Status and command point bank between fieldbus master and host CPU
`timescale 1ns/1ps
module fieldbus_master_host_flags
  import fieldbus_flags_pkg::*;
#(
  parameter int unsigned FAST_HALF_CYCLES = FAST_BLINK_CYCLES,
  parameter int unsigned SLOW_HALF_CYCLES = SLOW_BLINK_CYCLES
) (
  input  wire logic                       CLOCK_IN,
  input  wire logic                       RESET_N_IN,
  input  wire logic [POINT_COUNT-1:0]     COMMAND_POINTS_IN,
  output logic      [POINT_COUNT-1:0]     STATUS_POINTS_OUT,
  input  wire logic                       GROUND_SHORT_IN,
  input  wire logic                       SUPPLY_SHORT_IN,
  input  wire logic                       SUPPLY_LOW_IN,
  input  wire logic                       LINE_OPEN_IN,
  input  wire logic                       SLAVE_ERROR_IN,
  input  wire logic                       SLAVE_POWER_OFF_IN,
  input  wire logic                       WATCHDOG_ERROR_IN,
  input  wire logic [SETTING_WIDTH-1:0]   POINT_SETTING_IN,
  input  wire logic                       WAVE_MODE_IN,
  input  wire logic                       DETECT_SWITCH_IN,
  input  wire logic                       DETECT_DONE_IN,
  input  wire logic                       ERROR_ADDR_VALID_IN,
  input  wire logic [ERR_ADDR_WIDTH-1:0]  ERROR_ADDR_IN,
  input  wire logic [ERR_INDEX_WIDTH-1:0] ERROR_READ_INDEX_IN,
  output logic      [ERR_ADDR_WIDTH-1:0]  ERROR_READ_DATA_OUT,
  output logic      [ERR_COUNT_WIDTH-1:0] ERROR_COUNT_OUT,
  output logic                            ALARM_OUT,
  output logic                            WAVEFORM_ENABLE_OUT,
  output logic                            DETECT_START_OUT
);

  // Reset release
  logic reset_meta_reg;
  logic reset_sync_reg;
  logic rst_n;

  always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      reset_meta_reg <= 1'h0;
      reset_sync_reg <= 1'h0;
    end else begin
      reset_meta_reg <= 1'h1;
      reset_sync_reg <= reset_meta_reg;
    end
  end

  assign rst_n = reset_sync_reg;

  // Pin synchronisation
  sync_in_type sync_raw;
  sync_in_type sync_level;
  sync_in_type sync_rise;
  logic [SYNC_WIDTH-1:0] level_bits;
  logic [SYNC_WIDTH-1:0] rise_bits;

  assign sync_raw.cmd             = command_points_type'(COMMAND_POINTS_IN);
  assign sync_raw.ground_short    = GROUND_SHORT_IN;
  assign sync_raw.supply_short    = SUPPLY_SHORT_IN;
  assign sync_raw.supply_low      = SUPPLY_LOW_IN;
  assign sync_raw.line_open       = LINE_OPEN_IN;
  assign sync_raw.slave_error     = SLAVE_ERROR_IN;
  assign sync_raw.slave_power_off = SLAVE_POWER_OFF_IN;
  assign sync_raw.watchdog_error  = WATCHDOG_ERROR_IN;
  assign sync_raw.point_setting   = POINT_SETTING_IN;
  assign sync_raw.wave_mode       = WAVE_MODE_IN;
  assign sync_raw.detect_switch   = DETECT_SWITCH_IN;

  point_sync_edge #(
    .WIDTH (SYNC_WIDTH)
  ) u_sync (
    .clk_in    (CLOCK_IN),
    .rst_n_in  (rst_n),
    .async_in  (sync_raw),
    .level_out (level_bits),
    .rise_out  (rise_bits)
  );

  assign sync_level = sync_in_type'(level_bits);
  assign sync_rise  = sync_in_type'(rise_bits);

  // Command edges, reserved command points are never decoded
  logic clear_rise;
  logic detect_rise;
  logic wave_rise;

  assign clear_rise  = sync_rise.cmd.disconnect_clear_cmd;
  assign detect_rise = sync_rise.cmd.address_detect_cmd
                     | sync_rise.detect_switch;
  assign wave_rise   = sync_rise.cmd.waveform_start_cmd;

  // Operating state
  logic ok_reg;
  logic ok_next;

  assign ok_next = ok_reg & ~sync_level.watchdog_error;

  always_ff @(posedge CLOCK_IN or negedge rst_n) begin
    if (!rst_n) begin
      ok_reg <= 1'h1;
    end else begin
      ok_reg <= ok_next;
    end
  end

  // Line fault flags
  logic disconnect_cause;
  logic disconnect_reg;
  logic disconnect_next;
  logic ground_short_reg;
  logic supply_short_reg;
  logic supply_fault_reg;

  assign disconnect_cause = sync_level.line_open
                          | sync_level.slave_error
                          | sync_level.slave_power_off;

  // Cause present keeps the flag set through a clear
  assign disconnect_next = disconnect_cause
                         | (disconnect_reg & ~clear_rise);

  always_ff @(posedge CLOCK_IN or negedge rst_n) begin
    if (!rst_n) begin
      ground_short_reg <= 1'h0;
      supply_short_reg <= 1'h0;
      supply_fault_reg <= 1'h0;
      disconnect_reg   <= 1'h0;
    end else begin
      ground_short_reg <= sync_level.ground_short;
      supply_short_reg <= sync_level.supply_short;
      supply_fault_reg <= sync_level.supply_low;
      disconnect_reg   <= disconnect_next;
    end
  end

  // Error address list
  logic [ERR_ADDR_WIDTH-1:0]  err_mem [ERR_LIST_DEPTH];
  logic [ERR_COUNT_WIDTH-1:0] err_count_reg;
  logic [ERR_COUNT_WIDTH-1:0] err_count_next;
  logic                       err_discard;
  logic                       err_store;
  logic [ERR_INDEX_WIDTH-1:0] err_wr_index;
  logic                       rd_in_range;
  logic [ERR_ADDR_WIDTH-1:0]  rd_data_next;
  logic [ERR_ADDR_WIDTH-1:0]  rd_data_reg;

  assign err_discard  = clear_rise & ~disconnect_cause;
  assign err_store    = ERROR_ADDR_VALID_IN
                      & (err_count_reg < ERR_COUNT_MAX);
  assign err_wr_index = err_count_reg[ERR_INDEX_WIDTH-1:0];

  // Discard drops stale entries, a new one lands at slot 0 unless the list was full, then it is dropped too
  assign err_count_next =
      err_discard ? (err_store ? 8'h01 : ERR_COUNT_ZERO) :
      err_store   ? err_count_reg + 8'h01 :
                    err_count_reg;

  always_ff @(posedge CLOCK_IN) begin
    if (err_store) begin
      if (err_discard) begin
        err_mem[0] <= ERROR_ADDR_IN;
      end else begin
        err_mem[err_wr_index] <= ERROR_ADDR_IN;
      end
    end
  end

  always_ff @(posedge CLOCK_IN or negedge rst_n) begin
    if (!rst_n) begin
      err_count_reg <= ERR_COUNT_ZERO;
    end else begin
      err_count_reg <= err_count_next;
    end
  end

  assign rd_in_range  = {1'h0, ERROR_READ_INDEX_IN} < err_count_reg;
  assign rd_data_next = rd_in_range ? err_mem[ERROR_READ_INDEX_IN]
                                    : ERR_ADDR_ZERO;

  always_ff @(posedge CLOCK_IN or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_reg <= ERR_ADDR_ZERO;
    end else begin
      rd_data_reg <= rd_data_next;
    end
  end

  // Automatic address detection
  logic busy_reg;
  logic busy_next;
  logic detect_go;
  logic detect_pulse_reg;

  assign detect_go = detect_rise & ok_reg & ~busy_reg;
  assign busy_next = detect_go | (busy_reg & ~DETECT_DONE_IN);

  always_ff @(posedge CLOCK_IN or negedge rst_n) begin
    if (!rst_n) begin
      busy_reg         <= 1'h0;
      detect_pulse_reg <= 1'h0;
    end else begin
      busy_reg         <= busy_next;
      detect_pulse_reg <= detect_go;
    end
  end

  // Transmission waveform
  logic       wave_cmd_mode;
  logic       wave_reg;
  logic       wave_next;
  logic [1:0] settle_reg;

  assign wave_cmd_mode = sync_level.wave_mode == WAVE_MODE_CMD;
  // Held off until the mode pin has crossed both sync stages
  assign wave_next =
      !(ok_reg & settle_reg[1]) ? 1'h0 :
      wave_cmd_mode             ? (wave_reg | wave_rise) :
                                  1'h1;

  always_ff @(posedge CLOCK_IN or negedge rst_n) begin
    if (!rst_n) begin
      wave_reg   <= 1'h0;
      settle_reg <= 2'h0;
    end else begin
      wave_reg   <= wave_next;
      settle_reg <= {settle_reg[0], 1'h1};
    end
  end

  // Alarm indicator blink timing
  logic [BLINK_CNT_WIDTH-1:0] fast_cnt_reg;
  logic [BLINK_CNT_WIDTH-1:0] slow_cnt_reg;
  logic                       fast_phase_reg;
  logic                       slow_phase_reg;
  logic                       fast_wrap;
  logic                       slow_wrap;
  logic                       alarm_reg;
  logic                       alarm_next;

  assign fast_wrap = fast_cnt_reg
                   == BLINK_CNT_WIDTH'(FAST_HALF_CYCLES - 1);
  assign slow_wrap = slow_cnt_reg
                   == BLINK_CNT_WIDTH'(SLOW_HALF_CYCLES - 1);

  always_ff @(posedge CLOCK_IN or negedge rst_n) begin
    if (!rst_n) begin
      fast_cnt_reg   <= '0;
      slow_cnt_reg   <= '0;
      fast_phase_reg <= 1'h0;
      slow_phase_reg <= 1'h0;
    end else begin
      fast_cnt_reg   <= fast_wrap ? '0 : fast_cnt_reg + 1'h1;
      slow_cnt_reg   <= slow_wrap ? '0 : slow_cnt_reg + 1'h1;
      fast_phase_reg <= fast_phase_reg ^ fast_wrap;
      slow_phase_reg <= slow_phase_reg ^ slow_wrap;
    end
  end

  // Steady for disconnect, fast for shorts, slow for supply
  assign alarm_next =
      disconnect_reg                        ? 1'h1 :
      (ground_short_reg | supply_short_reg) ? fast_phase_reg :
      supply_fault_reg                      ? slow_phase_reg :
                                              1'h0;

  always_ff @(posedge CLOCK_IN or negedge rst_n) begin
    if (!rst_n) begin
      alarm_reg <= 1'h0;
    end else begin
      alarm_reg <= alarm_next;
    end
  end

  // Status point assembly
  status_points_type status_next;
  logic [POINT_COUNT-1:0] status_reg;

  always_comb begin
    status_next = status_points_type'(POINTS_ZERO);
    status_next.operating_ok_flag        = ok_next;
    status_next.signal_ground_short_flag = ground_short_reg;
    status_next.signal_supply_short_flag = supply_short_reg;
    status_next.supply_fault_flag        = supply_fault_reg;
    status_next.line_disconnect_flag     = disconnect_reg;
    status_next.point_count_mirror = sync_level.point_setting;
    status_next.detect_busy_flag         = busy_reg;
  end

  always_ff @(posedge CLOCK_IN or negedge rst_n) begin
    if (!rst_n) begin
      status_reg <= POINTS_ZERO;
    end else begin
      status_reg <= status_next;
    end
  end

  // Outputs
  assign STATUS_POINTS_OUT   = status_reg;
  assign ERROR_COUNT_OUT     = err_count_reg;
  assign ERROR_READ_DATA_OUT = rd_data_reg;
  assign ALARM_OUT           = alarm_reg;
  assign WAVEFORM_ENABLE_OUT = wave_reg;
  assign DETECT_START_OUT    = detect_pulse_reg;

endmodule : fieldbus_master_host_flags

// ### hdl/point_sync_edge.sv
// Two-stage synchroniser with rising-edge detect for a bus of pin inputs
`timescale 1ns/1ps
module point_sync_edge #(
  parameter int unsigned WIDTH = 8
) (
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] level_out,
  output logic      [WIDTH-1:0] rise_out
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] last_reg;

  // Only sync_reg reads meta_reg
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_reg <= '0;
      sync_reg <= '0;
      last_reg <= '0;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  assign level_out = sync_reg;
  assign rise_out  = sync_reg & ~last_reg;

endmodule : point_sync_edge
